// ---- bbr_map.vh ----
// register map, field positions, reset values and codes for the
// backlight/bias i2c register bank; definitions only.
`ifndef BBR_MAP_VH
`define BBR_MAP_VH
`define BBR_SLAVE_ADDR 7'h11
`define BBR_REG_REVISION 8'h01
`define BBR_REG_BL_CFG_A 8'h02
`define BBR_REG_BL_CFG_B 8'h03
`define BBR_REG_BRT_LOW 8'h04
`define BBR_REG_BRT_HIGH 8'h05
`define BBR_REG_FTH_LOW 8'h06
`define BBR_REG_FTH_HIGH 8'h07
`define BBR_REG_BL_EN 8'h08
`define BBR_REG_BIAS_CFG 8'h09
`define BBR_RST_BL_CFG_A 8'h28
`define BBR_RST_BL_CFG_B 8'h8d
`define BBR_RST_BRT_LOW 8'h07
`define BBR_RST_BRT_HIGH 8'hff
`define BBR_RST_BRIGHTNESS 11'h7ff
`define BBR_RST_FTH 8'h00
`define BBR_RST_BL_EN 8'h00
`define BBR_RST_BIAS_CFG 8'h18
`define BBR_SOFT_RESET_BIT 7
`define BBR_BL_EN_MASK 8'h7f
`define BBR_BRT_LOW_MASK 8'h07
`define BBR_FSEL_250K 2'h0
`define BBR_FSEL_500K 2'h1
`define BBR_FSEL_1M 2'h2
`define BBR_MODE_OFF 3'h0
`define BBR_MODE_NORMAL 3'h4
`define BBR_MODE_AUTO 3'h5
`define BBR_MODE_WAKE1 3'h6
`define BBR_MODE_WAKE2 3'h7
`define BBR_OVP_CODE_MAX 3'h3
`endif

// ---- bbr_sync.v ----
// two-flop synchroniser for one level from outside the ref_clk domain.
// assumes ref_clk; first flop feeds only the second.
`timescale 1ns/100ps
module bbr_sync (
	input wire ref_clk,
	input wire srst,
	input wire rst_val,
	input wire d,
	output reg q
);
	reg meta_q;

	// two stages, reset to the idle level of the pin
	always @(posedge ref_clk) begin
		if (srst) begin
			meta_q <= rst_val;
			q <= rst_val;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ---- bbr_freq_sel.v ----
// boost switching frequency choice from brightness and thresholds.
// pure combinational; inputs come from registers on ref_clk.
`timescale 1ns/100ps
`include "bbr_map.vh"
module bbr_freq_sel (
	input wire [7:0] brightness_high,
	input wire [7:0] freq_threshold_low,
	input wire [7:0] freq_threshold_high,
	output reg [1:0] freq_code
);
	// thresholds compare against the high brightness byte only
	always @* begin
		if (brightness_high < freq_threshold_low)
			freq_code = `BBR_FSEL_250K;
		else if (brightness_high > freq_threshold_high)
			freq_code = `BBR_FSEL_1M;
		else
			freq_code = `BBR_FSEL_500K;
	end
endmodule

// ---- bbr_regs.v ----
// i2c slave register bank of a backlight driver with display bias.
// assumes scl/sda from an open-drain bus, much slower than ref_clk.
`timescale 1ns/100ps
`include "bbr_map.vh"
module bbr_regs #(
	parameter [5:0] CHIP_REVISION = 6'h00, // arbitrary value
	parameter [1:0] MAKER_CODE = 2'h0 // arbitrary value
) (
	input wire ref_clk,
	input wire srst,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire bias_enable_pin_b,
	output reg [2:0] overvoltage_level_sel,
	output reg overvoltage_trip_off,
	output reg dimming_curve_sel,
	output reg dim_input_polarity,
	output reg dim_input_ramp_on,
	output reg dim_input_on,
	output reg boost_freq_sel,
	output reg [3:0] ramp_duration,
	output reg dim_sample_rate,
	output reg [1:0] dim_code_hysteresis,
	output reg [10:0] brightness,
	output reg [1:0] auto_freq_code,
	output reg backlight_on,
	output reg [3:0] string_on,
	output reg [2:0] bias_mode_sel,
	output reg bias_mode_valid,
	output reg positive_discharge_on,
	output reg negative_discharge_on,
	output reg positive_rail_on,
	output reg negative_rail_on,
	output reg bias_pin_control,
	output reg ramp_abort
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_ACK = 3'h2;
	localparam [2:0] ST_RXD = 3'h3;
	localparam [2:0] ST_TXD = 3'h4;
	localparam [2:0] ST_MACK = 3'h5;
	localparam [2:0] ST_START = 3'h6;

	wire scl_s;
	wire sda_s;
	wire pinb_s;
	reg scl_q, sda_q;
	reg [2:0] st_q;
	reg [7:0] sh_q;
	reg [2:0] bit_q;
	reg rw_q;
	reg have_ptr_q;
	reg [7:0] ptr_q;
	reg [7:0] cfg_a_q, cfg_b_q, brt_lo_q, brt_hi_q;
	reg [7:0] fth_lo_q, fth_hi_q, en_q, bias_q;
	reg [10:0] brt_q;
	reg soft_rst_q;
	wire [1:0] fcode;

	// bus pins and the bias pin are asynchronous to ref_clk
	bbr_sync u_scl (.ref_clk(ref_clk), .srst(srst), .rst_val(1'b1),
		.d(scl_in), .q(scl_s));
	bbr_sync u_sda (.ref_clk(ref_clk), .srst(srst), .rst_val(1'b1),
		.d(sda_in), .q(sda_s));
	bbr_sync u_pinb (.ref_clk(ref_clk), .srst(srst), .rst_val(1'b0),
		.d(bias_enable_pin_b), .q(pinb_s));

	bbr_freq_sel u_fsel (.brightness_high(brt_hi_q),
		.freq_threshold_low(fth_lo_q), .freq_threshold_high(fth_hi_q),
		.freq_code(fcode));

	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_c = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_c = scl_s & scl_q & ~sda_q & sda_s;

	// read mux; unmapped addresses read zero
	function [7:0] rd_mux;
		input [7:0] a;
		begin
			case (a)
			`BBR_REG_REVISION: rd_mux = {CHIP_REVISION, MAKER_CODE};
			`BBR_REG_BL_CFG_A: rd_mux = cfg_a_q;
			`BBR_REG_BL_CFG_B: rd_mux = cfg_b_q;
			`BBR_REG_BRT_LOW: rd_mux = brt_lo_q;
			`BBR_REG_BRT_HIGH: rd_mux = brt_hi_q;
			`BBR_REG_FTH_LOW: rd_mux = fth_lo_q;
			`BBR_REG_FTH_HIGH: rd_mux = fth_hi_q;
			`BBR_REG_BL_EN: rd_mux = en_q;
			`BBR_REG_BIAS_CFG: rd_mux = bias_q;
			default: rd_mux = 8'h00;
			endcase
		end
	endfunction

	// edge history of the synchronised pins
	always @(posedge ref_clk) begin
		if (srst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// i2c slave engine and register writes
	always @(posedge ref_clk) begin
		if (srst || soft_rst_q) begin
			st_q <= ST_IDLE;
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			rw_q <= 1'b0;
			have_ptr_q <= 1'b0;
			ptr_q <= 8'h00;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			cfg_a_q <= `BBR_RST_BL_CFG_A;
			cfg_b_q <= `BBR_RST_BL_CFG_B;
			brt_lo_q <= `BBR_RST_BRT_LOW;
			brt_hi_q <= `BBR_RST_BRT_HIGH;
			brt_q <= `BBR_RST_BRIGHTNESS;
			fth_lo_q <= `BBR_RST_FTH;
			fth_hi_q <= `BBR_RST_FTH;
			en_q <= `BBR_RST_BL_EN;
			bias_q <= `BBR_RST_BIAS_CFG;
			soft_rst_q <= 1'b0;
		end else if (start_c) begin
			st_q <= ST_START;
			bit_q <= 3'h0;
			sda_oe <= 1'b0;
		end else if (stop_c) begin
			st_q <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (st_q)
			// the scl fall closing a start is not a bit
			ST_START: begin
				if (scl_fall)
					st_q <= ST_ADDR;
			end
			ST_IDLE: sda_oe <= 1'b0;
			ST_ADDR, ST_RXD: begin
				if (scl_rise) begin
					sh_q <= {sh_q[6:0], sda_s};
				end else if (scl_fall) begin
					bit_q <= bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						if (st_q == ST_ADDR &&
							sh_q[7:1] != `BBR_SLAVE_ADDR) begin
							st_q <= ST_IDLE;
						end else begin
							if (st_q == ST_ADDR) begin
								rw_q <= sh_q[0];
								have_ptr_q <= 1'b0;
							end else if (!have_ptr_q) begin
								ptr_q <= sh_q;
								have_ptr_q <= 1'b1;
							end else begin
								ptr_q <= ptr_q + 8'h01;
								case (ptr_q)
								`BBR_REG_BL_CFG_A: cfg_a_q <= sh_q;
								`BBR_REG_BL_CFG_B: cfg_b_q <= sh_q;
								`BBR_REG_BRT_LOW: brt_lo_q <= sh_q;
								`BBR_REG_BRT_HIGH: begin
									brt_hi_q <= sh_q;
									brt_q <= {sh_q,
										brt_lo_q[2:0]};
								end
								`BBR_REG_FTH_LOW: fth_lo_q <= sh_q;
								`BBR_REG_FTH_HIGH: fth_hi_q <= sh_q;
								`BBR_REG_BL_EN: begin
									en_q <= sh_q & `BBR_BL_EN_MASK;
									soft_rst_q <=
										sh_q[`BBR_SOFT_RESET_BIT];
								end
								`BBR_REG_BIAS_CFG: bias_q <= sh_q;
								default: ;
								endcase
							end
							st_q <= ST_ACK;
							sda_oe <= 1'b1;
						end
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					bit_q <= 3'h0;
					if (rw_q && !have_ptr_q) begin
						st_q <= ST_TXD;
						sh_q <= rd_mux(ptr_q);
						// msb low means pull sda low
						sda_oe <= (rd_mux(ptr_q) < 8'h80);
						have_ptr_q <= 1'b1;
					end else begin
						st_q <= ST_RXD;
						sda_oe <= 1'b0;
					end
				end
			end
			ST_TXD: begin
				if (scl_fall) begin
					bit_q <= bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						st_q <= ST_MACK;
						sda_oe <= 1'b0;
						ptr_q <= ptr_q + 8'h01;
					end else begin
						sh_q <= {sh_q[6:0], 1'b0};
						sda_oe <= ~sh_q[6];
					end
				end
			end
			ST_MACK: begin
				if (scl_rise && sda_s)
					st_q <= ST_IDLE; // master nack ends the read
				else if (scl_fall) begin
					st_q <= ST_TXD;
					bit_q <= 3'h0;
					sh_q <= rd_mux(ptr_q);
					sda_oe <= (rd_mux(ptr_q) < 8'h80);
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	// registered function outputs; field decoding happens here, frequency choice in bbr_freq_sel
	always @(posedge ref_clk) begin
		if (srst) begin
			overvoltage_level_sel <= 3'h1;
			overvoltage_trip_off <= 1'b0;
			dimming_curve_sel <= 1'b1;
			dim_input_polarity <= 1'b0;
			dim_input_ramp_on <= 1'b0;
			dim_input_on <= 1'b0;
			boost_freq_sel <= 1'b1;
			ramp_duration <= 4'h1;
			dim_sample_rate <= 1'b1;
			dim_code_hysteresis <= 2'h1;
			brightness <= `BBR_RST_BRIGHTNESS;
			auto_freq_code <= `BBR_FSEL_250K;
			backlight_on <= 1'b0;
			string_on <= 4'h0;
			bias_mode_sel <= `BBR_MODE_OFF;
			bias_mode_valid <= 1'b1;
			positive_discharge_on <= 1'b1;
			negative_discharge_on <= 1'b1;
			positive_rail_on <= 1'b0;
			negative_rail_on <= 1'b0;
			bias_pin_control <= 1'b0;
			ramp_abort <= 1'b0;
		end else begin
			overvoltage_level_sel <= (cfg_a_q[7:5] > `BBR_OVP_CODE_MAX) ?
				`BBR_OVP_CODE_MAX : cfg_a_q[7:5];
			overvoltage_trip_off <= cfg_a_q[4];
			dimming_curve_sel <= cfg_a_q[3];
			dim_input_polarity <= cfg_a_q[2];
			dim_input_ramp_on <= cfg_a_q[1];
			dim_input_on <= cfg_a_q[0];
			boost_freq_sel <= cfg_b_q[7];
			ramp_duration <= cfg_b_q[6:3];
			dim_sample_rate <= cfg_b_q[2];
			dim_code_hysteresis <= cfg_b_q[1:0];
			brightness <= brt_q;
			auto_freq_code <= fcode;
			backlight_on <= en_q[4];
			string_on <= en_q[3:0];
			bias_mode_sel <= bias_q[7:5];
			bias_mode_valid <= (bias_q[7:5] == `BBR_MODE_OFF) ||
				bias_q[7];
			positive_discharge_on <= bias_q[4];
			negative_discharge_on <= bias_q[3];
			bias_pin_control <= bias_q[0];
			// rail enables; pin b gates under pin control
			positive_rail_on <= bias_q[2] & (~bias_q[0] | pinb_s);
			negative_rail_on <= bias_q[1] & (~bias_q[0] | pinb_s);
			// abort any ramp on soft reset
			ramp_abort <= soft_rst_q;
		end
	end
endmodule

// ---- bbr_regs_checker_assertions.sv ----
// concurrent checks on the ports of the register bank.
// assumes one ref_clk domain, srst synchronous and active high.
`timescale 1ns/100ps
module bbr_regs_checker (
	input wire ref_clk,
	input wire srst,
	input wire scl_in,
	input wire sda_oe,
	input wire bias_enable_pin_b,
	input wire [2:0] overvoltage_level_sel,
	input wire [10:0] brightness,
	input wire [1:0] auto_freq_code,
	input wire [3:0] string_on,
	input wire [2:0] bias_mode_sel,
	input wire bias_mode_valid,
	input wire positive_rail_on,
	input wire negative_rail_on,
	input wire bias_pin_control,
	input wire ramp_abort
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_rst; $fell(srst) |-> ##1 (brightness == 11'h7ff &&
		string_on == 4'h0 && auto_freq_code == 2'h2); endproperty
	a_rst: assert property (p_rst) else $error("bad reset value");
	property p_ovp; overvoltage_level_sel <= 3'h3; endproperty
	a_ovp: assert property (p_ovp) else $error("ovp not clamped");
	property p_freq; $stable(brightness) [*3] ##0
		brightness[10:3] == 8'h00 |-> auto_freq_code != 2'h2; endproperty
	a_freq: assert property (p_freq) else $error("freq too high");
	property p_valid; $stable(bias_mode_sel) [*2] |-> bias_mode_valid ==
		(bias_mode_sel == 3'h0 || bias_mode_sel[2]); endproperty
	a_valid: assert property (p_valid) else $error("mode decode");
	property p_pin; (bias_pin_control && !bias_enable_pin_b) [*6] |->
		!positive_rail_on && !negative_rail_on; endproperty
	a_pin: assert property (p_pin) else $error("rail on, pin low");
	property p_pulse; ramp_abort |=> !ramp_abort; endproperty
	a_pulse: assert property (p_pulse) else $error("abort too long");
	property p_abort; ramp_abort |-> ##[0:2]
		(brightness == 11'h7ff && string_on == 4'h0); endproperty
	a_abort: assert property (p_abort) else $error("not restored");
	property p_ack; $changed(sda_oe) |-> !scl_in; endproperty
	a_ack: assert property (p_ack) else $error("sda moved, scl high");
	property p_brt; $changed(brightness) |-> !scl_in; endproperty
	a_brt: assert property (p_brt) else $error("brightness glitch");
endmodule

// ---- bbr_host.sv ----
// i2c master standing in for the host processor.
// assumes a pull-up on sda; drv high pulls sda low.
`timescale 1ns/100ps
module bbr_host (
	input wire sda,
	output logic scl,
	output logic drv
);
	// idle bus: both lines released
	initial begin
		scl = 1'b1;
		drv = 1'b0;
	end
	task start;
		drv = 1'b0;
		#50 scl = 1'b1;
		#60 drv = 1'b1;
		#60 scl = 1'b0;
	endtask
	// stop leaves the bus released
	task stop;
		#40 drv = 1'b1;
		#40 scl = 1'b1;
		#60 drv = 1'b0;
		#60;
	endtask
	// nine bits msb first, a one releases sda so the slave can drive
	task xfer(input [8:0] d, output [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			#50 drv = !d[i];
			#12.5 scl = 1'b1;
			#31 q[i] = sda;
			#31.5 scl = 1'b0;
		end
	endtask
endmodule

// ---- bbr_regs_bench.sv ----
// self-checking bench for the i2c register bank.
// assumes bbr_host as bus master and the checker bound below.
`timescale 1ns/100ps
module bbr_regs_bench;
	logic ref_clk = 0;
	logic srst = 1;
	logic bias_enable_pin_b = 0;
	wire scl_in, m_drv, sda_out, sda_oe, overvoltage_trip_off;
	wire dimming_curve_sel, dim_input_polarity, dim_input_ramp_on;
	wire dim_input_on, boost_freq_sel, dim_sample_rate, backlight_on;
	wire bias_mode_valid, positive_discharge_on, negative_discharge_on;
	wire positive_rail_on, negative_rail_on, bias_pin_control, ramp_abort;
	wire [1:0] dim_code_hysteresis, auto_freq_code;
	wire [2:0] overvoltage_level_sel, bias_mode_sel;
	wire [3:0] ramp_duration, string_on;
	wire [10:0] brightness;
	// wired-and sda with pull-up
	wire sda_in = !(m_drv || (sda_oe && !sda_out));
	wire [4:0] cfg_a = {overvoltage_trip_off, dimming_curve_sel,
		dim_input_polarity, dim_input_ramp_on, dim_input_on};
	wire [7:0] cfg_b = {boost_freq_sel, ramp_duration, dim_sample_rate,
		dim_code_hysteresis};
	wire [4:0] en_v = {backlight_on, string_on};
	wire [5:0] bias_v = {bias_mode_sel, positive_discharge_on,
		negative_discharge_on, bias_pin_control};
	wire [1:0] rail_v = {positive_rail_on, negative_rail_on};
	logic [8:0] r;
	logic [7:0] wb[9], rb[9];
	logic [7:0] rst_v[8] = '{8'h28, 8'h8d, 8'h07, 8'hff, 8'h00, 8'h00,
		8'h00, 8'h18};
	logic [7:0] fb[6] = '{8'h00, 8'h3f, 8'h40, 8'h41, 8'h80, 8'h81};
	logic [10:0] got, exp_q[$];
	logic abort_seen = 0;
	int miscompares = 0, n_tests = 0, cyc = 0;
	event res_ev;
	bbr_regs bbr_regs_inst (.*);
	bbr_host bbr_host_inst (.sda(sda_in), .scl(scl_in), .drv(m_drv));
	always #5 ref_clk = !ref_clk;
	// watcher: oldest note against each published result
	always @(res_ev) begin
		n_tests++;
		if (exp_q[0] !== got) begin
			miscompares++;
			$display("ERROR %0t exp %h got %h", $time, exp_q[0], got);
		end
		void'(exp_q.pop_front());
	end
	// hang guard and abort pulse catcher
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			tally_and_finish();
		end
		if (ramp_abort)
			abort_seen <= 1'b1;
	end
	task note(input [10:0] e, input [10:0] g);
		exp_q.push_back(e);
		got = g;
		->res_ev;
		#1;
	endtask
	function automatic logic [10:0] fexp(input [7:0] v, lo, hi);
		return v < lo ? 11'h0 : v > hi ? 11'h2 : 11'h1;
	endfunction
	// slave address 0x11 shifted left, r/w in bit 0
	task wr(input [7:0] a, input int n);
		bbr_host_inst.start();
		bbr_host_inst.xfer({8'h22, 1'b1}, r);
		note(11'h0, 11'(r[0]));
		bbr_host_inst.xfer({a, 1'b1}, r);
		for (int i = 0; i < n; i++)
			bbr_host_inst.xfer({wb[i], 1'b1}, r);
		bbr_host_inst.stop();
	endtask
	task rd(input [7:0] a, input int n);
		bbr_host_inst.start();
		bbr_host_inst.xfer({8'h22, 1'b1}, r);
		bbr_host_inst.xfer({a, 1'b1}, r);
		bbr_host_inst.start();
		bbr_host_inst.xfer({8'h23, 1'b1}, r);
		for (int i = 0; i < n; i++) begin
			bbr_host_inst.xfer({8'hff, i == n - 1}, r);
			rb[i] = r[8:1];
		end
		bbr_host_inst.stop();
	endtask
	task chk_rst;
		rd(8'h02, 8);
		for (int i = 0; i < 8; i++)
			note(11'(rst_v[i]), 11'(rb[i]));
	endtask
	task tally_and_finish;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// main sequence
	initial begin
		void'($urandom(32'h6a656192));
		repeat (6) @(posedge ref_clk);
		#1 srst = 0;
		repeat (4) @(posedge ref_clk);
		chk_rst();
		bbr_host_inst.start();
		bbr_host_inst.xfer({8'h24, 1'b1}, r);
		bbr_host_inst.stop();
		note(11'h1, 11'(r[0]));
		// write 0x01..0x09 in one go; 0x01 is read-only
		for (int k = 0; k < 8; k++) begin
			foreach (wb[i])
				wb[i] = 8'($urandom);
			wb[7] &= 8'h1f;
			wb[8][7:5] = 3'(k);
			wb[8][0] = k[1];
			@(posedge ref_clk);
			#1 bias_enable_pin_b = k[0];
			wr(8'h01, 9);
			repeat (6) @(posedge ref_clk);
			note(wb[1][7:5] > 3 ? 11'h3 : 11'(wb[1][7:5]),
				11'(overvoltage_level_sel));
			note(11'(wb[1][4:0]), 11'(cfg_a));
			note(11'(wb[2]), 11'(cfg_b));
			note({wb[4], wb[3][2:0]}, brightness);
			note(fexp(wb[4], wb[5], wb[6]), 11'(auto_freq_code));
			note(11'(wb[7][4:0]), 11'(en_v));
			note(11'({wb[8][7:3], wb[8][0]}), 11'(bias_v));
			note(11'(wb[8][2:1] & {2{!k[1] || k[0]}}), 11'(rail_v));
			note(11'(k == 0 || k > 3), 11'(bias_mode_valid));
			rd(8'h01, 9);
			note(11'h0, 11'(rb[0]));
			for (int i = 1; i < 9; i++)
				note(11'(wb[i]), 11'(rb[i]));
		end
		wb[0] = 8'h02;
		wr(8'h04, 1);
		note({wb[4], wb[3][2:0]}, brightness);
		wb[0] = 8'h40;
		wb[1] = 8'h80;
		wr(8'h06, 2);
		// threshold boundaries, low bits committed on each high write
		foreach (fb[i]) begin
			wb[0] = fb[i];
			wr(8'h05, 1);
			repeat (6) @(posedge ref_clk);
			note(fexp(fb[i], 8'h40, 8'h80), 11'(auto_freq_code));
			note({fb[i], 3'h2}, brightness);
		end
		rd(8'h20, 1);
		note(11'h0, 11'(rb[0]));
		wb[0] = 8'h80;
		wr(8'h08, 1);
		note(11'h1, 11'(abort_seen));
		chk_rst();
		tally_and_finish();
	end
endmodule
bind bbr_regs bbr_regs_checker bbr_regs_checker_inst (.*);
